/* File: hdl/wpc_consts.svh */
// Offsets, field positions, reset values and the implemented bit mask for the weak pull control block
`ifndef WPC_CONSTS_SVH
`define WPC_CONSTS_SVH
// Register byte addresses on the bus
`define WPC_OFS_DIR 8'h00
`define WPC_OFS_EN 8'h04
`define WPC_OFS_CFG 8'h08
`define WPC_OFS_STAT 8'h0C
// Implemented bit mask of both pull registers (bits 5,4,2,1,0)
`define WPC_IMPL_MASK 8'h37
// Reset value of both pull registers
`define WPC_PULL_RST 8'h37
// Pin positions with write locks, and the master clear pin
`define WPC_PIN_OSC_IN 5
`define WPC_PIN_XTAL_OUT 4
`define WPC_PIN_MASTER_CLEAR 3
// Config register fields
`define WPC_CFG_GPE 0
`define WPC_CFG_RST 8'h01
// Unmapped read answer
`define WPC_UNMAPPED_DATA 32'h0000_0000
`endif

/* File: hdl/wpc_pkg.sv */
// Types shared by the weak pull control block
package wpc_pkg;
	// Per-pin pull drive result
	typedef struct packed {
		logic [5:0] up;
		logic [5:0] down;
	} wpc_pull_t;
	// Bus access kinds
	typedef enum logic [1:0] {
		WPC_ACC_IDLE = 2'b00,
		WPC_ACC_ACK = 2'b01
	} wpc_acc_t;
	// Pin usage conditions
	typedef struct packed {
		logic [5:0] dir_in;
		logic [5:0] analog;
		logic [5:0] clk_fn;
	} wpc_pinuse_t;
endpackage

/* File: hdl/wpc_pull_regs.sv */
// Storage of the pull direction and pull enable registers with write locks
`include "wpc_consts.svh"
module wpc_pull_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Write side
	input wire logic wr_dir,
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	input wire logic lock_osc_in,
	input wire logic lock_xtal_out,
	// Stored values
	output logic [7:0] dir_ff,
	output logic [7:0] en_ff
);
	// Masked write data; unimplemented bits never store
	wire [7:0] nxt_dir = wr_dir ? (wdata & `WPC_IMPL_MASK) : dir_ff; // [R1] [R7]
	wire [7:0] en_keep = {2'b00, lock_osc_in, lock_xtal_out, 4'b0000};
	// Locked bits keep their value, others take the write
	wire [7:0] en_wr = ((wdata & ~en_keep) | (en_ff & en_keep)) & `WPC_IMPL_MASK;
	wire [7:0] nxt_en = wr_en ? en_wr : en_ff; // [R2] [R5] [R6] [R7]

	// Registers update one clock after the write is accepted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dir_ff <= `WPC_PULL_RST; // [R8]
			en_ff <= `WPC_PULL_RST; // [R8]
		end else begin
			dir_ff <= nxt_dir; // [R9]
			en_ff <= nxt_en; // [R9]
		end
	end
endmodule

/* File: hdl/wpc_top.sv */
// Weak pull control: registers, pull gating and Wishbone slave
// Functional notes
// [R1] Direction bit 1 pulls up, 0 pulls down
// [R2] Enable bit 1 enables the pin pull
// [R3] Pull needs global, input, enable, digital
// [R4] Pin three pulls up as master clear
// [R5] Pin5 enable locked unless internal osc only
// [R6] Pin4 enable locked when crystal output
// [R7] Bits 7,6,3 unimplemented, read zero
// [R8] Implemented bits reset to one
// [R9] Byte registers, write effective next clock
`include "wpc_consts.svh"
module wpc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pin usage and oscillator configuration
	input wire logic [5:0] pin_direction_control,
	input wire logic [5:0] pin_analog,
	input wire logic [5:0] pin_clock_fn,
	input wire logic internal_oscillator,
	input wire logic timer1_oscillator,
	input wire logic crystal_output_pin,
	input wire logic master_clear_function,
	input wire logic program_mode,
	// Pull drive outputs
	output logic [5:0] pull_up_ff,
	output logic [5:0] pull_down_ff
);
	// Register contents
	logic [7:0] dir_ff;
	logic [7:0] en_ff;
	logic [7:0] cfg_ff;
	logic [7:0] nxt_cfg;
	logic ack_ff;
	logic [31:0] dat_ff;
	wpc_pkg::wpc_pull_t nxt_pull;

	// Notes for whoever integrates this block:
	// - Pin usage and oscillator inputs are taken as synchronous to clk.
	// - Pulls lag every input or register change by one clock; the extra
	//   flop keeps the pins free of decode glitches.
	// - A locked enable bit keeps what was stored, so dropping the lock
	//   shows the value last written while the pin was free.
	// - Software can read the applied pull-ups back through the status word.

	// Lock conditions for the two guarded enable bits
	wire lock_osc_in = !(internal_oscillator && !timer1_oscillator); // [R5]
	wire lock_xtal_out = crystal_output_pin; // [R6]

	// Decode; a request is taken once, ack drops the next cycle
	wire req = wb_cyc_i && wb_stb_i && !ack_ff;
	wire hit_dir = wb_adr_i == `WPC_OFS_DIR;
	wire hit_en = wb_adr_i == `WPC_OFS_EN;
	wire hit_cfg = wb_adr_i == `WPC_OFS_CFG;
	wire hit_stat = wb_adr_i == `WPC_OFS_STAT;
	// Writes need the low byte lane since registers are 8 bits wide
	wire wr_ok = req && wb_we_i && wb_sel_i[0];
	wire wr_dir = wr_ok && hit_dir; // [R9]
	wire wr_en = wr_ok && hit_en; // [R9]
	wire wr_cfg = wr_ok && hit_cfg;

	// Locked bits read as one regardless of the stored value
	wire [7:0] en_view = en_ff | {2'b00, lock_osc_in, lock_xtal_out, 4'b0000}; // [R5] [R6]
	wire [7:0] rd_byte = hit_dir ? dir_ff :
		hit_en ? en_view :
		hit_cfg ? cfg_ff :
		hit_stat ? {2'b00, pull_up_ff} : 8'h00; // [R7]
	wire rd_mapped = hit_dir || hit_en || hit_cfg || hit_stat;
	wire [31:0] rd_word = rd_mapped ? {24'h00_0000, rd_byte} : `WPC_UNMAPPED_DATA;

	// Register storage with write locks
	wpc_pull_regs u_regs (
		.clk(clk),
		.resetn(resetn),
		.wr_dir(wr_dir),
		.wr_en(wr_en),
		.wdata(wb_dat_i[7:0]),
		.lock_osc_in(lock_osc_in),
		.lock_xtal_out(lock_xtal_out),
		.dir_ff(dir_ff),
		.en_ff(en_ff)
	);

	// Global enable lives in config bit 0
	assign nxt_cfg = wr_cfg ? {7'h00, wb_dat_i[`WPC_CFG_GPE]} : cfg_ff;

	// Pull gating: all conditions must hold together
	wire [5:0] gate = {6{cfg_ff[`WPC_CFG_GPE]}} & pin_direction_control
		& en_view[5:0] & ~pin_analog & ~pin_clock_fn; // [R3]
	// Pin three has no pull register path; only master clear pulls it
	wire mclear_up = master_clear_function && !program_mode; // [R4]

	// Next pull levels; registered below so the pins never see a glitch
	always_comb begin
		// Direction picks up or down only where the gate is open
		nxt_pull.up = gate & dir_ff[5:0]; // [R1]
		nxt_pull.down = gate & ~dir_ff[5:0]; // [R1]
		// Pin three override: pull-up from master clear, never pull-down
		nxt_pull.up[`WPC_PIN_MASTER_CLEAR] = mclear_up; // [R4]
		nxt_pull.down[`WPC_PIN_MASTER_CLEAR] = 1'b0; // [R4]
	end

	// Bus answer, config and pull outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
			cfg_ff <= `WPC_CFG_RST;
			pull_up_ff <= 6'h00;
			pull_down_ff <= 6'h00;
		end else begin
			ack_ff <= req;
			dat_ff <= req ? rd_word : dat_ff;
			cfg_ff <= nxt_cfg;
			pull_up_ff <= nxt_pull.up;
			pull_down_ff <= nxt_pull.down;
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// Assertions, grouped by rule; all run on clk and rest during reset.
	// Pull outputs are registered, so most checks look one clock ahead.

	// Up direction lies behind every pull-up on pin0
	property p_dir_sel;
		@(posedge clk) disable iff (!resetn)
		pull_up_ff[0] |-> $past(dir_ff[0]);
	endproperty
	a_dir_sel: assert property (p_dir_sel) else $error("pull-up without up direction"); // [R1]
	// Down direction lies behind every pull-down on pin0
	property p_dir_down;
		@(posedge clk) disable iff (!resetn)
		pull_down_ff[0] |-> !$past(dir_ff[0]);
	endproperty
	a_dir_down: assert property (p_dir_down) else $error("pull-down on up direction"); // [R1]
	// A pin is never pulled both ways at once
	property p_up_down_excl;
		@(posedge clk) disable iff (!resetn)
		(pull_up_ff & pull_down_ff) == 6'h00;
	endproperty
	a_up_down_excl: assert property (p_up_down_excl) else $error("pin pulled both ways"); // [R1]

	// A pull on pin1 needs its enable bit
	property p_en_gate;
		@(posedge clk) disable iff (!resetn)
		(pull_up_ff[1] || pull_down_ff[1]) |-> $past(en_ff[1]);
	endproperty
	a_en_gate: assert property (p_en_gate) else $error("pull on disabled pin"); // [R2]
	// A cleared enable bit removes the pull on pin2
	property p_en_off;
		@(posedge clk) disable iff (!resetn)
		!en_view[2] |=> !pull_up_ff[2] && !pull_down_ff[2];
	endproperty
	a_en_off: assert property (p_en_off) else $error("pull kept on disabled pin"); // [R2]

	// A closed gate on pin2 removes its pull
	property p_gate;
		@(posedge clk) disable iff (!resetn)
		(!cfg_ff[`WPC_CFG_GPE] || !pin_direction_control[2] || pin_analog[2])
			|=> !pull_up_ff[2] && !pull_down_ff[2];
	endproperty
	a_gate: assert property (p_gate) else $error("pull with gate closed"); // [R3]
	// With every condition met pin0 is pulled one way; flops still in reset excluded
	property p_gate_open;
		@(posedge clk) disable iff (!resetn)
		(resetn && cfg_ff[`WPC_CFG_GPE] && pin_direction_control[0] && en_view[0]
			&& !pin_analog[0] && !pin_clock_fn[0]) |=> pull_up_ff[0] || pull_down_ff[0];
	endproperty
	a_gate_open: assert property (p_gate_open) else $error("open gate left pin unpulled"); // [R3]
	// Clock use of pin5 removes its pull
	property p_clock_use;
		@(posedge clk) disable iff (!resetn)
		pin_clock_fn[5] |=> !pull_up_ff[5] && !pull_down_ff[5];
	endproperty
	a_clock_use: assert property (p_clock_use) else $error("pull on clock pin"); // [R3]
	// Analog use of pin0 removes its pull
	property p_analog_use;
		@(posedge clk) disable iff (!resetn)
		pin_analog[0] |=> !pull_up_ff[0] && !pull_down_ff[0];
	endproperty
	a_analog_use: assert property (p_analog_use) else $error("pull on analog pin"); // [R3]
	// Output pin1 is never pulled
	property p_out_pin;
		@(posedge clk) disable iff (!resetn)
		!pin_direction_control[1] |=> !pull_up_ff[1] && !pull_down_ff[1];
	endproperty
	a_out_pin: assert property (p_out_pin) else $error("pull on output pin"); // [R3]
	// Global enable written over the bus lands next clock
	property p_cfg_wr;
		@(posedge clk) disable iff (!resetn)
		wr_cfg |=> cfg_ff[`WPC_CFG_GPE] == $past(wb_dat_i[`WPC_CFG_GPE]);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("global enable write lost"); // [R3]

	// Master clear pulls pin three up; flops still in reset excluded
	property p_pin3_up;
		@(posedge clk) disable iff (!resetn)
		(resetn && master_clear_function && !program_mode) |=> pull_up_ff[3];
	endproperty
	a_pin3_up: assert property (p_pin3_up) else $error("pin three not pulled up"); // [R4]
	// Without master clear, or while programming, pin three floats
	property p_pin3_off;
		@(posedge clk) disable iff (!resetn)
		!(master_clear_function && !program_mode) |=> !pull_up_ff[3];
	endproperty
	a_pin3_off: assert property (p_pin3_off) else $error("pin three pulled up"); // [R4]
	// Pin three is never pulled down
	property p_pin3_down;
		@(posedge clk) disable iff (!resetn)
		!pull_down_ff[`WPC_PIN_MASTER_CLEAR];
	endproperty
	a_pin3_down: assert property (p_pin3_down) else $error("pin three pulled down"); // [R4]

	// Locked pin5 enable keeps its stored value
	property p_lock5;
		@(posedge clk) disable iff (!resetn)
		$past(lock_osc_in) |-> en_ff[5] == $past(en_ff[5]);
	endproperty
	a_lock5: assert property (p_lock5) else $error("locked pin5 enable changed"); // [R5]
	// Locked pin5 enable reads back as one
	property p_lock5_rd;
		@(posedge clk) disable iff (!resetn)
		(req && hit_en && !wb_we_i && lock_osc_in) |=> wb_dat_o[5];
	endproperty
	a_lock5_rd: assert property (p_lock5_rd) else $error("locked pin5 enable reads zero"); // [R5]
	// Free pin5 enable takes the written bit
	property p_free5_wr;
		@(posedge clk) disable iff (!resetn)
		(wr_en && !lock_osc_in) |=> en_ff[5] == $past(wb_dat_i[5]);
	endproperty
	a_free5_wr: assert property (p_free5_wr) else $error("pin5 enable write lost"); // [R5]

	// Locked pin4 enable keeps its stored value
	property p_lock4;
		@(posedge clk) disable iff (!resetn)
		(lock_xtal_out && $past(lock_xtal_out)) |-> en_ff[4] == $past(en_ff[4]);
	endproperty
	a_lock4: assert property (p_lock4) else $error("locked pin4 enable changed"); // [R6]
	// Locked pin4 enable reads back as one
	property p_lock4_rd;
		@(posedge clk) disable iff (!resetn)
		(req && hit_en && !wb_we_i && lock_xtal_out) |=> wb_dat_o[4];
	endproperty
	a_lock4_rd: assert property (p_lock4_rd) else $error("locked pin4 enable reads zero"); // [R6]
	// Free pin4 enable takes the written bit
	property p_free4_wr;
		@(posedge clk) disable iff (!resetn)
		(wr_en && !lock_xtal_out) |=> en_ff[4] == $past(wb_dat_i[4]);
	endproperty
	a_free4_wr: assert property (p_free4_wr) else $error("pin4 enable write lost"); // [R6]

	// Unimplemented bits never store
	property p_unimpl;
		@(posedge clk) disable iff (!resetn)
		(dir_ff & ~`WPC_IMPL_MASK) == 8'h00 && (en_ff & ~`WPC_IMPL_MASK) == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // [R7]
	// Direction reads show zero in unimplemented places
	property p_unimpl_rd;
		@(posedge clk) disable iff (!resetn)
		(req && hit_dir && !wb_we_i) |=> wb_dat_o[7:6] == 2'b00 && !wb_dat_o[3];
	endproperty
	a_unimpl_rd: assert property (p_unimpl_rd) else $error("unimplemented bit reads one"); // [R7]

	// Direction write lands next clock
	property p_wr_next;
		@(posedge clk) disable iff (!resetn)
		wr_dir |=> dir_ff == ($past(wb_dat_i[7:0]) & `WPC_IMPL_MASK);
	endproperty
	a_wr_next: assert property (p_wr_next) else $error("direction write not applied"); // [R9]
	// Enable write with no lock lands next clock
	property p_en_next;
		@(posedge clk) disable iff (!resetn)
		(wr_en && !lock_osc_in && !lock_xtal_out)
			|=> en_ff == ($past(wb_dat_i[7:0]) & `WPC_IMPL_MASK);
	endproperty
	a_en_next: assert property (p_en_next) else $error("enable write not applied"); // [R9]
	// A write without lane zero changes nothing
	property p_lane_drop;
		@(posedge clk) disable iff (!resetn)
		(req && wb_we_i && !wb_sel_i[0]) |=> dir_ff == $past(dir_ff) && en_ff == $past(en_ff);
	endproperty
	a_lane_drop: assert property (p_lane_drop) else $error("write without lane zero applied"); // [R9]
	// Every taken request is answered next clock
	property p_ack_next;
		@(posedge clk) disable iff (!resetn)
		req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not acknowledged"); // [R9]
	// Ack is a single-cycle pulse
	property p_ack_one;
		@(posedge clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held two cycles"); // [R9]
	// No ack without a request
	property p_ack_idle;
		@(posedge clk) disable iff (!resetn)
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request"); // [R9]
	// Upper read lanes are always zero
	property p_rd_upper;
		@(posedge clk) disable iff (!resetn)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read lanes not zero"); // [R9]

	// Main scenarios the bench should reach
	c_write_dir: cover property (@(posedge clk) disable iff (!resetn) wr_dir);
	c_lock5: cover property (@(posedge clk) disable iff (!resetn) wr_en && lock_osc_in);
	c_lock4: cover property (@(posedge clk) disable iff (!resetn) wr_en && lock_xtal_out);
	c_pulldown: cover property (@(posedge clk) disable iff (!resetn) pull_down_ff != 6'h00);
	c_master_clear: cover property (@(posedge clk) disable iff (!resetn) pull_up_ff[3]);
endmodule

/* File: verif/wpc_top_bench.sv */
// Self-checking bench for the weak pull control block over Wishbone
`include "wpc_consts.svh"
module wpc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// Clock, reset and bus signals
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat_o, rv;
	logic ack;
	// Pin usage and oscillator levels
	logic [5:0] pdir = 6'h3F, pana = 6'h00, pclk = 6'h00;
	logic iosc = 1'b1, t1o = 1'b0, xto = 1'b0, mcf = 1'b0, pgm = 1'b0;
	logic [5:0] up, dn;
	int err_total = 0;
	int samples_checked = 0;
	always #25 clk = ~clk;
	wpc_top i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack),
		.pin_direction_control(pdir), .pin_analog(pana), .pin_clock_fn(pclk),
		.internal_oscillator(iosc), .timer1_oscillator(t1o), .crystal_output_pin(xto),
		.master_clear_function(mcf), .program_mode(pgm), .pull_up_ff(up), .pull_down_ff(dn));
	// Compare one value and count it
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic cycle; the request holds until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h00_0000, d};
		forever begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		rv = rdat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00, 4'hF);
		chk("rdata", rv, exp);
	endtask
	// Pulls are registered, so give them a few cycles to settle
	task automatic pchk(input logic [5:0] eu, input logic [5:0] ed);
		repeat (3) @(posedge clk);
		chk("pull_up", {26'h000_0000, up}, {26'h000_0000, eu});
		chk("pull_down", {26'h000_0000, dn}, {26'h000_0000, ed});
	endtask
	// Verdict and end of run
	task automatic results();
		if (err_total == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog: the sequence needs well under two thousand cycles
	initial begin
		#(50 * 5000);
		err_total++;
		results();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(`WPC_OFS_DIR, 32'h0000_0037);
		rd(`WPC_OFS_EN, 32'h0000_0037);
		pchk(6'h37, 6'h00);
		rd(`WPC_OFS_CFG, 32'h0000_0001);
		rd(`WPC_OFS_STAT, 32'h0000_0037);
		wr(`WPC_OFS_DIR, 8'hFF);
		rd(`WPC_OFS_DIR, 32'h0000_0037);
		wr(`WPC_OFS_DIR, 8'h00);
		rd(`WPC_OFS_DIR, 32'h0000_0000);
		pchk(6'h00, 6'h37);
		wr(`WPC_OFS_DIR, 8'h05);
		pchk(6'h05, 6'h32);
		wr(`WPC_OFS_EN, 8'h03);
		pchk(6'h01, 6'h02);
		wr(`WPC_OFS_EN, 8'hF0);
		rd(`WPC_OFS_EN, 32'h0000_0030);
		wr(`WPC_OFS_EN, 8'h37);
		// Analog on pin0, clock use on pin5, pin1 driven as output
		pana <= 6'h01;
		pclk <= 6'h20;
		pdir <= 6'h3D;
		pchk(6'h04, 6'h10);
		pana <= 6'h00;
		pclk <= 6'h00;
		pdir <= 6'h3F;
		wr(`WPC_OFS_CFG, 8'h00);
		pchk(6'h00, 6'h00);
		mcf <= 1'b1;
		pchk(6'h08, 6'h00);
		rd(`WPC_OFS_STAT, 32'h0000_0008);
		pgm <= 1'b1;
		pchk(6'h00, 6'h00);
		pgm <= 1'b0;
		mcf <= 1'b0;
		wr(`WPC_OFS_CFG, 8'h01);
		// Write with lane 0 off is dropped
		xfer(1'b1, `WPC_OFS_EN, 8'h00, 4'hE);
		rd(`WPC_OFS_EN, 32'h0000_0037);
		// Pin5 enable locked while the timer1 oscillator runs
		t1o <= 1'b1;
		wr(`WPC_OFS_EN, 8'h00);
		rd(`WPC_OFS_EN, 32'h0000_0020);
		pchk(6'h00, 6'h20);
		t1o <= 1'b0;
		iosc <= 1'b0;
		wr(`WPC_OFS_EN, 8'h00);
		rd(`WPC_OFS_EN, 32'h0000_0020);
		iosc <= 1'b1;
		xto <= 1'b1;
		wr(`WPC_OFS_EN, 8'h00);
		rd(`WPC_OFS_EN, 32'h0000_0010);
		xto <= 1'b0;
		wr(`WPC_OFS_EN, 8'h00);
		rd(`WPC_OFS_EN, 32'h0000_0000);
		// Reset in mid-run brings both pull registers back to their defaults
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(`WPC_OFS_DIR, 32'h0000_0037);
		rd(`WPC_OFS_EN, 32'h0000_0037);
		// Unmapped place: acked, write lost, reads zero
		wr(8'h10, 8'hFF);
		rd(8'h10, 32'h0000_0000);
		results();
	end
endmodule
